// *** logic/ddcz_pkg.sv ***
// constants of the first downconverter channel: register map, fields,
// widths and mode encodings.
// assumes byte-wide registers reached by word on APB (address = 4*index).
package ddcz_pkg;
  // register indices; byte address on APB is four times the index
  localparam logic [9:0] IDX_CTRL = 10'h310;
  localparam logic [9:0] IDX_ISEL = 10'h311;
  localparam logic [9:0] IDX_TWL = 10'h314;
  localparam logic [9:0] IDX_TWH = 10'h315;
  localparam logic [9:0] IDX_PWL = 10'h320;
  localparam logic [9:0] IDX_PWH = 10'h321;
  localparam logic [9:0] IDX_OTST = 10'h327;
  localparam logic [7:0] REG_RST = 8'h00;
  // control fields
  localparam int CTRL_MIX_B = 7;
  localparam int CTRL_GAIN_B = 6;
  localparam int CTRL_IFM_LSB = 4;
  localparam int CTRL_C2R_B = 3;
  localparam int CTRL_DEC_LSB = 0;
  // select bits of input select and output test registers; mask of tuning and phase high registers
  localparam int SEL_I_B = 0;
  localparam int SEL_Q_B = 2;
  localparam logic [7:0] SEL_MASK = 8'h05;
  localparam logic [7:0] HI_MASK = 8'h0f;
  // datapath
  localparam int DW = 14;
  localparam int NW = 12;
  localparam int FRAC = 11;
  localparam int FIFO_DEPTH = 16;
  localparam logic [13:0] FS_POS = 14'h1fff;
  typedef enum logic [1:0] {
    IF_VAR = 2'b00,
    IF_ZERO = 2'b01,
    IF_FS4 = 2'b10,
    IF_TEST = 2'b11
  } ddcz_ifm_t;
  // decimation codes
  localparam logic [1:0] DEC_C11 = 2'b11;
  localparam logic [1:0] DEC_C00 = 2'b00;
  localparam logic [1:0] DEC_C01 = 2'b01;
  localparam logic [1:0] DEC_C10 = 2'b10;
endpackage : ddcz_pkg

// *** logic/ddcz_fifo.sv ***
// synchronous FIFO with valid/ready on both sides, show-ahead read.
// assumes one clock; width and depth are parameters.
`timescale 1ns/100ps
`default_nettype none
module ddcz_fifo #(
  parameter int W = 28,
  parameter int D = 16
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } ddcz_fifo_st_t;
  ddcz_fifo_st_t st_ff, nxt_st;
  logic push, pop;

  assign in_ready = st_ff.cnt != (AW+1)'(D);
  assign out_valid = st_ff.cnt != '0;
  assign out_data = st_ff.mem[st_ff.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    nxt_st = st_ff;
    if (push) begin
      nxt_st.mem[st_ff.wp] = in_data;
      nxt_st.wp = st_ff.wp + 1'b1;
    end
    if (pop) begin
      nxt_st.rp = st_ff.rp + 1'b1;
    end
    nxt_st.cnt = st_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule : ddcz_fifo
`default_nettype wire

// *** logic/ddcz_nco.sv ***
// 12-bit oscillator: phase accumulator, phase offset, 16-point cos/sin.
// assumes advance pulses once per accepted input sample.
`timescale 1ns/100ps
`default_nettype none
module ddcz_nco
  import ddcz_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic advance,
  input wire logic hold,
  input wire logic quarter,
  input wire logic [NW-1:0] frequency_tuning_word,
  input wire logic [NW-1:0] phase_offset_word,
  output logic signed [NW-1:0] cos_o,
  output logic signed [NW-1:0] sin_o
);
  typedef struct packed {
    logic [NW-1:0] acc;
    logic [1:0] qcnt;
  } ddcz_nco_st_t;
  ddcz_nco_st_t st_ff, nxt_st;
  logic [NW-1:0] phase;
  logic [3:0] idx;

  // coarse table keeps area small; spur level set by 4-bit phase
  function automatic logic [NW-1:0] cos_lut(input logic [3:0] k);
    case (k)
      4'h0: cos_lut = 12'h7ff;
      4'h1, 4'hf: cos_lut = 12'h763;
      4'h2, 4'he: cos_lut = 12'h5a7;
      4'h3, 4'hd: cos_lut = 12'h30f;
      4'h5, 4'hb: cos_lut = 12'hcf1;
      4'h6, 4'ha: cos_lut = 12'ha59;
      4'h7, 4'h9: cos_lut = 12'h89d;
      4'h8: cos_lut = 12'h801;
      default: cos_lut = 12'h000;
    endcase
  endfunction : cos_lut

  assign phase = st_ff.acc + phase_offset_word;
  assign idx = quarter ? {st_ff.qcnt, 2'b00} : phase[NW-1:NW-4];
  assign cos_o = cos_lut(idx);
  assign sin_o = cos_lut(idx - 4'h4);

  always_comb begin
    nxt_st = st_ff;
    if (advance) begin
      if (quarter) begin
        nxt_st.qcnt = st_ff.qcnt + 2'b01;
      end else if (!hold) begin
        nxt_st.acc = st_ff.acc + frequency_tuning_word;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  a_acc_step: assert property (@(posedge clk) disable iff (!rst_b)
    advance && !hold && !quarter |=>
      st_ff.acc == $past(st_ff.acc) + $past(frequency_tuning_word))
    else $error("accumulator did not step by tuning word");
  a_acc_hold: assert property (@(posedge clk) disable iff (!rst_b)
    hold && !quarter |=> $stable(st_ff.acc))
    else $error("accumulator moved while oscillator disabled");
endmodule : ddcz_nco
`default_nettype wire

// *** logic/ddcz_top.sv ***
// first downconverter channel: APB registers, input routing, mixer,
// gain, complex-to-real, decimation, output test and output FIFO.
// assumes converter samples and APB share clk; sink drives out_ready.
//
// The APB register port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
// Operation
// - IF mode 00 runs variable IF with mixers and oscillator active.
// - IF mode 01 bypasses mixer, stops oscillator; 10 mixes by fs/4.
// - IF mode 11 forces mixer inputs to +full scale, oscillator runs.
// - complex-to-real off: codes 11,00,01,10 decimate by 2,4,8,16.
// - complex-to-real on: codes 11,00,01,10 decimate by 1,2,4,8.
// - input select bit 0 routes I, bit 2 routes Q; 0=A, 1=B.
// - tuning word is 12-bit twos complement over low and high register.
// - phase word is 12-bit twos complement over low and high register.
module ddcz_top
  import ddcz_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [DW-1:0] ch_a_data,
  input wire logic [DW-1:0] ch_b_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [DW-1:0] out_i,
  output logic [DW-1:0] out_q,
  output logic out_valid,
  input wire logic out_ready
);
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] isel;
    logic [7:0] twl;
    logic [7:0] twh;
    logic [7:0] pwl;
    logic [7:0] pwh;
    logic [7:0] otst;
    logic [3:0] dcnt;
    logic sv;
    logic [DW-1:0] si;
    logic [DW-1:0] sq;
  } ddcz_st_t;
  ddcz_st_t st_ff, nxt_st;

  logic [9:0] idx;
  logic hit;
  logic wr_en;
  logic [7:0] rd_byte;
  logic [NW-1:0] frequency_tuning_word;
  logic [NW-1:0] phase_offset_word;
  ddcz_ifm_t ifm;
  logic cplx_mix;
  logic gain6;
  logic c2r;
  logic [1:0] dec_code;
  logic [2:0] dec_log2;
  logic [3:0] ratio_m1;
  logic signed [DW-1:0] in_i;
  logic signed [DW-1:0] in_q;
  logic signed [DW-1:0] mix_in_i;
  logic signed [DW-1:0] mix_in_q;
  logic signed [NW-1:0] nco_cos;
  logic signed [NW-1:0] nco_sin;
  logic signed [27:0] acc_i;
  logic signed [27:0] acc_q;
  logic signed [DW-1:0] mix_i;
  logic signed [DW-1:0] mix_q;
  logic signed [DW-1:0] g_i;
  logic signed [DW-1:0] g_q;
  logic [DW-1:0] res_i;
  logic [DW-1:0] res_q;
  logic accept;
  logic emit;
  logic f_in_ready;
  logic [2*DW-1:0] f_out;

  // clip to 14 bits so overdrive does not wrap sign
  function automatic logic [DW-1:0] sat(input logic signed [27:0] v);
    if (v > 28'sd8191) begin
      sat = 14'h1fff;
    end else if (v < -28'sd8192) begin
      sat = 14'h2000;
    end else begin
      sat = v[DW-1:0];
    end
  endfunction : sat

  // register bus decode
  assign idx = paddr[11:2];
  assign hit = (paddr[1:0] == 2'b00) &&
    (idx == IDX_CTRL || idx == IDX_ISEL || idx == IDX_TWL ||
     idx == IDX_TWH || idx == IDX_PWL || idx == IDX_PWH ||
     idx == IDX_OTST);
  assign wr_en = psel && penable && pwrite && hit;
  // zero wait states; unmapped words answer with an error
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;

  always_comb begin
    case (idx)
      IDX_CTRL: rd_byte = st_ff.ctrl;
      IDX_ISEL: rd_byte = st_ff.isel;
      IDX_TWL: rd_byte = st_ff.twl;
      IDX_TWH: rd_byte = st_ff.twh;
      IDX_PWL: rd_byte = st_ff.pwl;
      IDX_PWH: rd_byte = st_ff.pwh;
      IDX_OTST: rd_byte = st_ff.otst;
      default: rd_byte = 8'h00;
    endcase
  end
  assign prdata = (psel && hit) ? {24'h000000, rd_byte} : 32'h00000000;

  // control fields
  assign ifm = ddcz_ifm_t'(st_ff.ctrl[CTRL_IFM_LSB +: 2]);
  assign cplx_mix = st_ff.ctrl[CTRL_MIX_B];
  assign gain6 = st_ff.ctrl[CTRL_GAIN_B];
  assign c2r = st_ff.ctrl[CTRL_C2R_B];
  assign dec_code = st_ff.ctrl[CTRL_DEC_LSB +: 2];
  assign frequency_tuning_word = {st_ff.twh[3:0], st_ff.twl};
  assign phase_offset_word = {st_ff.pwh[3:0], st_ff.pwl};

  // log2 of the decimation ratio; complex-to-real halves it
  always_comb begin
    case (dec_code)
      DEC_C11: dec_log2 = 3'd1;
      DEC_C00: dec_log2 = 3'd2;
      DEC_C01: dec_log2 = 3'd3;
      DEC_C10: dec_log2 = 3'd4;
      default: dec_log2 = 3'd1;
    endcase
    if (c2r) begin
      dec_log2 = dec_log2 - 3'd1;
    end
  end
  assign ratio_m1 = 4'((5'd1 << dec_log2) - 5'd1);

  // input routing
  assign in_i = st_ff.isel[SEL_I_B] ? ch_b_data : ch_a_data;
  assign in_q = st_ff.isel[SEL_Q_B] ? ch_b_data : ch_a_data;
  assign mix_in_i = (ifm == IF_TEST) ? FS_POS : in_i;
  assign mix_in_q = (ifm == IF_TEST) ? FS_POS : in_q;

  ddcz_nco u_nco (
    .clk(clk),
    .rst_b(rst_b),
    .advance(accept),
    .hold(ifm == IF_ZERO),
    .quarter(ifm == IF_FS4),
    .frequency_tuning_word(frequency_tuning_word),
    .phase_offset_word(phase_offset_word),
    .cos_o(nco_cos),
    .sin_o(nco_sin)
  );

  // real mixer uses I only; complex mixer rotates the I/Q pair
  always_comb begin
    if (cplx_mix) begin
      acc_i = 28'(mix_in_i * nco_cos) + 28'(mix_in_q * nco_sin);
      acc_q = 28'(mix_in_q * nco_cos) - 28'(mix_in_i * nco_sin);
    end else begin
      acc_i = 28'(mix_in_i * nco_cos);
      acc_q = -28'(mix_in_i * nco_sin);
    end
  end

  always_comb begin
    if (ifm == IF_ZERO) begin
      mix_i = in_i;
      mix_q = cplx_mix ? in_q : 14'h0000;
    end else begin
      mix_i = sat(acc_i >>> FRAC);
      mix_q = sat(acc_q >>> FRAC);
    end
  end

  // 6 dB gain is a left shift with clipping
  assign g_i = gain6 ? sat(28'(mix_i) <<< 1) : mix_i;
  assign g_q = gain6 ? sat(28'(mix_q) <<< 1) : mix_q;

  // complex-to-real keeps the real part; Q path is zeroed
  always_comb begin
    res_i = g_i;
    res_q = c2r ? 14'h0000 : g_q;
    if (st_ff.otst[SEL_I_B]) begin
      res_i = ch_a_data;
    end
    if (st_ff.otst[SEL_Q_B]) begin
      res_q = ch_b_data;
    end
  end

  // one output stage; stalls the source when the stage holds a sample and the FIFO is full
  assign in_ready = !st_ff.sv || f_in_ready;
  assign accept = in_valid && in_ready;
  assign emit = accept && (st_ff.dcnt >= ratio_m1);

  always_comb begin
    nxt_st = st_ff;
    if (wr_en) begin
      case (idx)
        IDX_CTRL: nxt_st.ctrl = pwdata[7:0];
        IDX_ISEL: nxt_st.isel = pwdata[7:0] & SEL_MASK;
        IDX_TWL: nxt_st.twl = pwdata[7:0];
        IDX_TWH: nxt_st.twh = pwdata[7:0] & HI_MASK;
        IDX_PWL: nxt_st.pwl = pwdata[7:0];
        IDX_PWH: nxt_st.pwh = pwdata[7:0] & HI_MASK;
        IDX_OTST: nxt_st.otst = pwdata[7:0] & SEL_MASK;
        default: nxt_st.ctrl = st_ff.ctrl;
      endcase
    end
    if (accept) begin
      nxt_st.dcnt = emit ? 4'h0 : st_ff.dcnt + 4'h1;
    end
    if (emit) begin
      nxt_st.sv = 1'b1;
      nxt_st.si = res_i;
      nxt_st.sq = res_q;
    end else if (f_in_ready) begin
      nxt_st.sv = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= '0;
      st_ff.ctrl <= REG_RST;
      st_ff.isel <= REG_RST;
      st_ff.twh <= REG_RST;
      st_ff.pwh <= REG_RST;
      st_ff.otst <= REG_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ddcz_fifo #(
    .W(2*DW),
    .D(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_b(rst_b),
    .in_valid(st_ff.sv),
    .in_ready(f_in_ready),
    .in_data({st_ff.si, st_ff.sq}),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(f_out)
  );
  assign out_i = f_out[2*DW-1:DW];
  assign out_q = f_out[DW-1:0];

  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  a_var_mixes: assert property (
    ifm == IF_VAR && !cplx_mix |-> mix_i == sat(acc_i >>> FRAC))
    else $error("variable IF output not the mixed product");
  a_zero_bypass: assert property (
    ifm == IF_ZERO |-> mix_i == in_i)
    else $error("0 Hz mode did not bypass the mixer");
  a_test_full: assert property (
    ifm == IF_TEST |-> mix_in_i == FS_POS && mix_in_q == FS_POS)
    else $error("test mode mixer inputs not at full scale");
  a_dec_emit: assert property (
    accept && !c2r && dec_code == DEC_C10 && st_ff.dcnt == 4'hf
      |=> st_ff.sv && st_ff.dcnt == 4'h0)
    else $error("decimate by 16 did not emit on sixteenth sample");
  a_dec_skip: assert property (
    accept && !c2r && dec_code == DEC_C00 && st_ff.dcnt == 4'h1
      |=> st_ff.dcnt == 4'h2)
    else $error("decimate by 4 emitted early");
  a_c2r_every: assert property (
    accept && c2r && dec_code == DEC_C11 |-> emit)
    else $error("decimate by 1 dropped a sample");
  a_isel_clean: assert property (
    (st_ff.isel & ~SEL_MASK) == 8'h00 && (st_ff.isel[SEL_I_B] ||
      in_i == ch_a_data))
    else $error("input select stray bits or wrong I routing");
  a_tw_pack: assert property (
    wr_en && idx == IDX_TWH |=> frequency_tuning_word[11:8] ==
      $past(pwdata[3:0]))
    else $error("tuning word high nibble not taken");
  a_pw_pack: assert property (
    wr_en && idx == IDX_PWL |=> phase_offset_word[7:0] ==
      $past(pwdata[7:0]))
    else $error("phase word low byte not taken");
  a_gain_shift: assert property (
    gain6 && mix_i[13] == mix_i[12] |-> g_i == {mix_i[12:0], 1'b0})
    else $error("6 dB gain not applied");
  a_test_out: assert property (
    emit && st_ff.otst[SEL_I_B] |=> st_ff.si == $past(ch_a_data))
    else $error("I output test pattern not from channel A");
  // known points of the table give known products
  a_var_product: assert property (
    ifm == IF_VAR && !cplx_mix && nco_cos == 12'h7ff &&
      nco_sin == 12'h000 && in_i == 14'h0100 |-> mix_i == 14'h00ff)
    else $error("variable IF product wrong at zero phase");
  a_zero_realq: assert property (
    ifm == IF_ZERO && !cplx_mix |-> mix_q == 14'h0000)
    else $error("0 Hz real mode left Q nonzero");
  a_fs4_quarter: assert property (
    ifm == IF_FS4 |-> (nco_cos == 12'h7ff && nco_sin == 12'h000) ||
      (nco_cos == 12'h000 && nco_sin == 12'h7ff) ||
      (nco_cos == 12'h801 && nco_sin == 12'h000) ||
      (nco_cos == 12'h000 && nco_sin == 12'h801))
    else $error("quarter-rate mixing left the four table points");
  a_test_product: assert property (
    ifm == IF_TEST && !cplx_mix && nco_cos == 12'h7ff &&
      nco_sin == 12'h000 |-> mix_i == 14'h1ffb)
    else $error("test mode product not full scale");
  a_dec2_emit: assert property (
    accept && !c2r && dec_code == DEC_C11 |-> emit == (st_ff.dcnt != 4'h0))
    else $error("decimate by 2 emitted on the wrong sample");
  a_dec8_ratio: assert property (
    dec_code == DEC_C01 |-> ratio_m1 == (c2r ? 4'h3 : 4'h7))
    else $error("decimation code 01 gave the wrong ratio");
  a_c2r_ratio: assert property (
    c2r && dec_code == DEC_C10 |-> ratio_m1 == 4'h7)
    else $error("complex-to-real code 10 did not decimate by 8");
  a_isel_q: assert property (
    st_ff.isel[SEL_Q_B] |-> in_q == ch_b_data)
    else $error("Q path not routed from channel B");
  a_tw_low: assert property (
    wr_en && idx == IDX_TWL |=> frequency_tuning_word[7:0] ==
      $past(pwdata[7:0]))
    else $error("tuning word low byte not taken");
  a_pw_high: assert property (
    wr_en && idx == IDX_PWH |=> phase_offset_word[11:8] ==
      $past(pwdata[3:0]))
    else $error("phase word high nibble not taken");
  a_c2r_zero: assert property (
    emit && c2r && !st_ff.otst[SEL_Q_B] |=>
      st_ff.sq == 14'h0000)
    else $error("complex-to-real left Q output nonzero");
  a_test_qout: assert property (
    emit && st_ff.otst[SEL_Q_B] |=> st_ff.sq == $past(ch_b_data))
    else $error("Q output test pattern not from channel B");
endmodule : ddcz_top
`default_nettype wire

// *** test/ddcz_stream_model.sv ***
// converter sample source and output sink beside the channel.
// assumes one clock; the bench steers it through send and stall.
`timescale 1ns/100ps
`default_nettype none
module ddcz_stream_model
  import ddcz_pkg::*;
(
  input wire logic clk,
  input wire logic in_ready,
  input wire logic out_valid,
  input wire logic [DW-1:0] out_i,
  input wire logic [DW-1:0] out_q,
  output logic [DW-1:0] ch_a_data,
  output logic [DW-1:0] ch_b_data,
  output logic in_valid,
  output logic out_ready
);
  logic [DW-1:0] got_i[$];
  logic [DW-1:0] got_q[$];
  logic stall = 1'b0;
  initial begin
    ch_a_data = '0;
    ch_b_data = '0;
    in_valid = 1'b0;
    out_ready = 1'b0;
  end
  always @(posedge clk) begin
    out_ready <= !stall;
  end
  // values settle by the falling edge; the pop lands on the next rise
  always @(negedge clk) begin
    if (out_valid && out_ready) begin
      got_i.push_back(out_i);
      got_q.push_back(out_q);
    end
  end
  task send(input int target, input int limit, input logic [DW-1:0] a,
            input logic [DW-1:0] b, output int cnt);
    int cyc;
    logic acc;
    cnt = 0;
    cyc = 0;
    @(posedge clk);
    in_valid <= 1'b1;
    ch_a_data <= a;
    ch_b_data <= b;
    while (cnt < target && cyc < limit) begin
      @(negedge clk);
      acc = in_ready;
      @(posedge clk);
      cyc++;
      if (acc) cnt++;
    end
    in_valid <= 1'b0;
    // released lines must not keep looking like valid samples
    ch_a_data <= ~a;
    ch_b_data <= ~b;
  endtask : send
endmodule : ddcz_stream_model
`default_nettype wire

// *** test/ddcz_tb_top.sv ***
// self-checking bench of the first downconverter channel.
// assumes ddcz_pkg, the design and ddcz_stream_model compiled first.
`timescale 1ns/100ps
`default_nettype none
module ddcz_tb_top
  import ddcz_pkg::*;
;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready, pslverr, in_ready, out_valid, in_valid, out_ready;
  logic [DW-1:0] ch_a_data, ch_b_data, out_i, out_q;
  int mismatches = 0;
  int cmp_count = 0;
  int n, cz, cp, cn;
  logic [31:0] rd;
  logic err;
  logic [9:0] ix[7] = '{IDX_CTRL, IDX_ISEL, IDX_TWL, IDX_TWH, IDX_PWL,
                        IDX_PWH, IDX_OTST};
  logic [7:0] rb[7] = '{8'hff, 8'h05, 8'hff, 8'h0f, 8'hff, 8'h0f, 8'h05};
  logic [1:0] dc[4] = '{DEC_C11, DEC_C00, DEC_C01, DEC_C10};

  initial begin
    forever #25 clk = ~clk;
  end

  ddcz_top ddcz_top_inst (.clk(clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ch_a_data(ch_a_data), .ch_b_data(ch_b_data), .in_valid(in_valid),
    .in_ready(in_ready), .out_i(out_i), .out_q(out_q),
    .out_valid(out_valid), .out_ready(out_ready));

  ddcz_stream_model ddcz_stream_model_inst (.clk(clk), .in_ready(in_ready),
    .out_valid(out_valid), .out_i(out_i), .out_q(out_q),
    .ch_a_data(ch_a_data), .ch_b_data(ch_b_data), .in_valid(in_valid),
    .out_ready(out_ready));

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task apb(input logic w, input logic [11:0] a, input logic [7:0] wd);
    logic rdy;
    @(posedge clk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= {24'h0, wd};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      // values seen here are those the edge samples; watchdog ends a hang
      rdy = pready;
      rd = prdata;
      err = pslverr;
    end while (rdy !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [9:0] idx, input logic [7:0] v);
    apb(1'b1, {idx, 2'b00}, v);
  endtask : wr

  task drain;
    int k;
    repeat (4) @(posedge clk);
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (out_valid !== 1'b0 && k < 60);
  endtask : drain

  // sixteen samples keep the decimation count aligned between runs
  task run(input logic [7:0] ctl, input logic [DW-1:0] a,
           input logic [DW-1:0] b, input int exp_n);
    wr(IDX_CTRL, ctl);
    ddcz_stream_model_inst.got_i.delete();
    ddcz_stream_model_inst.got_q.delete();
    ddcz_stream_model_inst.send(16, 200, a, b, n);
    drain();
    chk(ddcz_stream_model_inst.got_i.size(), exp_n);
  endtask : run

  task test_done;
    $display("checks %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done

  initial begin
    #2000000;
    mismatches++;
    test_done();
  end

  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, {ix[i], 2'b00}, 8'h00);
      chk(rd, {24'h0, REG_RST});
      wr(ix[i], 8'hff);
      apb(1'b0, {ix[i], 2'b00}, 8'h00);
      chk(rd, {24'h0, rb[i]});
      wr(ix[i], 8'h00);
    end
    apb(1'b0, 12'hc48, 8'h00);
    chk({rd[30:0], err}, 32'h1);
    $display("test registers done");
    wr(IDX_OTST, 8'h05);
    for (int i = 0; i < 4; i++) begin
      run({6'h00, dc[i]}, 14'h0123, 14'h2abc, 16 >> (i + 1));
      chk(ddcz_stream_model_inst.got_i[0], 14'h0123);
      chk(ddcz_stream_model_inst.got_q[0], 14'h2abc);
      run({6'h02, dc[i]}, 14'h0123, 14'h2abc, 16 >> i);
    end
    wr(IDX_OTST, 8'h00);
    $display("test decimation done");
    wr(IDX_ISEL, 8'h01);
    run(8'h93, 14'h0123, 14'h0456, 8);
    chk(ddcz_stream_model_inst.got_i[0], 14'h0456);
    chk(ddcz_stream_model_inst.got_q[0], 14'h0123);
    run(8'hd3, 14'h0123, 14'h0456, 8);
    chk(ddcz_stream_model_inst.got_i[0], 14'h08ac);
    chk(ddcz_stream_model_inst.got_q[0], 14'h0246);
    wr(IDX_ISEL, 8'h04);
    run(8'h13, 14'h0123, 14'h0456, 8);
    chk(ddcz_stream_model_inst.got_i[0], 14'h0123);
    chk(ddcz_stream_model_inst.got_q[0], 14'h0000);
    $display("test routing done");
    run(8'h33, 14'h0000, 14'h0000, 8);
    chk(ddcz_stream_model_inst.got_i[0], 14'h1ffb);
    wr(IDX_PWH, 8'h04);
    run(8'h33, 14'h0000, 14'h0000, 8);
    chk(ddcz_stream_model_inst.got_q[0], 14'h2004);
    wr(IDX_PWH, 8'h00);
    // half a turn a sample flips the sign of every decimated output
    wr(IDX_TWH, 8'h08);
    run(8'h0b, 14'h0100, 14'h0000, 16);
    for (int k = 0; k < 15; k++) begin
      chk(ddcz_stream_model_inst.got_i[k + 1],
          ~ddcz_stream_model_inst.got_i[k] & 14'h3fff);
    end
    wr(IDX_TWH, 8'h00);
    run(8'h2b, 14'h0100, 14'h0000, 16);
    cz = 0;
    cp = 0;
    cn = 0;
    foreach (ddcz_stream_model_inst.got_i[k]) begin
      cz += (ddcz_stream_model_inst.got_i[k] === 14'h0000);
      cp += (ddcz_stream_model_inst.got_i[k] === 14'h00ff);
      cn += (ddcz_stream_model_inst.got_i[k] === 14'h3f00);
    end
    chk({cz[7:0], cp[7:0], cn[7:0]}, 32'h080404);
    $display("test oscillator done");
    ddcz_stream_model_inst.stall = 1'b1;
    wr(IDX_CTRL, 8'h1b);
    ddcz_stream_model_inst.got_i.delete();
    ddcz_stream_model_inst.send(40, 40, 14'h0011, 14'h0000, n);
    chk(n, FIFO_DEPTH + 1);
    ddcz_stream_model_inst.stall = 1'b0;
    drain();
    chk(ddcz_stream_model_inst.got_i.size(), FIFO_DEPTH + 1);
    chk(out_valid, 1'b0);
    $display("test buffer done");
    test_done();
  end
endmodule : ddcz_tb_top
`default_nettype wire
